// ===== rtl/adcif_top.sv
/*
  Conversion control, parallel/byte read port and framed serial output of a
  12-bit sampling converter.
  Assumes every control pin and the converter clock are asynchronous and are
  synchronised here; i_sample_code is held stable by the analog side while
  the track/hold output is high.
*/
// What this block does
// - serial word: four zeros, then result MSB first
// - data changes on clock rise, valid on fall
// - strobe low within three clocks of start
// - serial clock, data, strobe are open-drain
// - serial clock derived from converter clock
// - continuous or per-word gated serial clock
// - strobe rising edge starts conversion, holds sample
// - strobe ignored while chip select is low
// - strobe mode: status is active-low interrupt
// - first read clears the interrupt
// - read latches disabled during conversion
// - optional power-up conversion leaves interrupt low
// - parallel format: one 12-bit read, no serial
// - strobe-mode byte read picks byte by select
// - select falling with byte select low starts
// - select mode: status is active-low busy
// - low byte read stalls until conversion ends
// - serial behaviour same in both modes
// - high byte right-justified, zeros above it
// - high select gives parallel, low gives serial/byte
// - track/hold returns to tracking at end
`timescale 1ns/100ps
module adcif_top
  import adcif_pkg::*;
#(
  parameter int           CONVERT_TICKS = CONV_TICKS, // converter clocks per conversion
  parameter bit           POWERUP_CONV  = 1'b1        // run one conversion after reset
) (
  input  wire logic                i_clock,             // 100 MHz block clock
  input  wire logic                i_resetn,            // async reset, active low
  input  wire logic                i_conv_clock,        // converter clock, asynchronous
  input  wire logic                i_conversion_strobe_n, // start strobe, active low
  input  wire logic                i_cs_n,              // chip select, active low
  input  wire logic                i_rd_n,              // read strobe, active low
  input  wire logic                i_upper_byte_select, // byte select, high picks upper
  input  wire logic [1:0]          i_format_select,     // format/clock select level
  input  wire logic                i_select_started,    // 1: chip-select start mode
  input  wire logic [RESULT_W-1:0] i_sample_code,       // code from the analog side
  output logic [RESULT_W-1:0]      o_data,              // read data pins
  output logic [RESULT_W-1:0]      o_data_oe,           // per-pin drive enable
  output logic                     o_status_n,          // interrupt or busy, active low
  output logic                     o_hold,              // track/hold in hold
  output logic                     o_serial_clock_oe,   // open-drain pull low
  output logic                     o_serial_data_out_oe, // open-drain pull low
  output logic                     o_serial_frame_strobe_n_oe // open-drain pull low
);
  typedef enum logic [1:0] {CV_IDLE = 2'b01, CV_RUN = 2'b10} adcif_conv_e;
  typedef enum logic [2:0] {SR_IDLE = 3'b001, SR_ARM = 3'b010, SR_SHIFT = 3'b100} adcif_ser_e;

  adcif_stream_if #(.WIDTH(RESULT_W)) push_if ();
  adcif_stream_if #(.WIDTH(RESULT_W)) pop_if ();

  adcif_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .push     (push_if.sink),
    .pop      (pop_if.source)
  );

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] last;
  logic [SYNC_W-1:0] raw_in;

  // two flops per pin; only sync2 and its delayed copy are looked at
  assign raw_in = {i_select_started, i_format_select, i_upper_byte_select,
                   i_rd_n, i_cs_n, i_conversion_strobe_n, i_conv_clock};

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      last  <= SYNC_RST;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      last  <= sync2;
    end
  end

  logic       clk_rise;
  logic       sel_mode;
  logic [1:0] fmt;
  logic       fmt_serial;
  logic       read_active;
  logic       read_fall;
  logic       conversion_strobe_n_rise;
  logic       cs_fall;

  assign clk_rise    = sync2[IX_CLK] & ~last[IX_CLK];
  assign sel_mode    = sync2[IX_SELMODE];
  assign fmt         = {sync2[IX_FMT1], sync2[IX_FMT0]};
  assign fmt_serial  = (fmt != FMT_PARALLEL);
  assign read_active = ~sync2[IX_CS_N] & ~sync2[IX_RD_N];
  assign read_fall   = read_active & ~(~last[IX_CS_N] & ~last[IX_RD_N]);
  assign conversion_strobe_n_rise = sync2[IX_CONVERSION_STROBE_N_N] & ~last[IX_CONVERSION_STROBE_N_N];
  assign cs_fall     = ~sync2[IX_CS_N] & last[IX_CS_N];

  adcif_conv_e         conv_state;
  adcif_conv_e         next_conv_state;
  logic [5:0]          tick_cnt;
  logic [5:0]          next_tick_cnt;
  logic [RESULT_W-1:0] result;
  logic [RESULT_W-1:0] next_result;
  logic                next_status_n;
  logic                next_hold;
  logic                pwrup;
  logic                next_pwrup;
  logic [1:0]          settled;
  logic [1:0]          next_settled;
  logic                push_valid;
  logic                next_push_valid;
  logic                start_req;
  logic                start;
  logic                conv_done;

  // strobe rising edge starts in strobe mode
  // chip select low blocks the strobe start
  // select falling with byte select low starts
  // power-up start waits until sync2 holds real pin levels, not the reset
  // pattern, so the format seen at that start is the one on the pins
  assign start_req = (pwrup & settled[1])
                   | (~sel_mode & conversion_strobe_n_rise & sync2[IX_CS_N])
                   | (sel_mode & cs_fall & ~sync2[IX_UBS] & ~sync2[IX_CONVERSION_STROBE_N_N]);
  // a full buffer refuses a serial conversion rather than dropping its word
  assign start     = (conv_state == CV_IDLE) & start_req & (~fmt_serial | push_if.ready);
  assign conv_done = (conv_state == CV_RUN) & clk_rise
                   & (tick_cnt == 6'(CONVERT_TICKS - 1));

  assign push_if.valid = push_valid;
  assign push_if.data  = result;

  // conversion sequencing and status pin
  always_comb begin
    next_conv_state = conv_state;
    next_tick_cnt   = tick_cnt;
    next_result     = result;
    next_status_n   = o_status_n;
    next_hold       = o_hold;
    next_pwrup      = pwrup & ~start;
    next_settled    = {settled[0], 1'b1};
    next_push_valid = 1'b0;
    unique case (conv_state)
      CV_IDLE: begin
        if (start) begin
          next_conv_state = CV_RUN;
          next_tick_cnt   = '0;
          next_hold       = 1'b1;
          next_result     = i_sample_code;
          // no serial word in parallel format
          next_push_valid = fmt_serial;
          if (sel_mode) begin
            next_status_n = 1'b0;
          end
        end
      end
      CV_RUN: begin
        if (clk_rise) begin
          next_tick_cnt = tick_cnt + 6'h01;
        end
        if (conv_done) begin
          next_conv_state = CV_IDLE;
          // back to tracking at the end
          next_hold       = 1'b0;
          // interrupt falls at end; busy rises
          // power-up conversion ends with interrupt low
          next_status_n   = sel_mode;
        end
      end
    endcase
    // first read clears interrupt; an end in the same cycle wins
    if (~sel_mode & read_fall & ~conv_done & (conv_state == CV_IDLE)) begin
      next_status_n = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      conv_state <= CV_IDLE;
      tick_cnt   <= 6'h00;
      result     <= RESULT_RST;
      o_status_n <= 1'b1;
      o_hold     <= 1'b0;
      pwrup      <= POWERUP_CONV;
      settled    <= 2'h0;
      push_valid <= 1'b0;
    end else begin
      conv_state <= next_conv_state;
      tick_cnt   <= next_tick_cnt;
      result     <= next_result;
      o_status_n <= next_status_n;
      o_hold     <= next_hold;
      pwrup      <= next_pwrup;
      settled    <= next_settled;
      push_valid <= next_push_valid;
    end
  end

  logic [RESULT_W-1:0] next_data;
  logic [RESULT_W-1:0] next_data_oe;

  // read port: latches dead while converting, so a select-mode read just waits
  always_comb begin
    next_data    = '0;
    next_data_oe = '0;
    // drive only while select and read low
    // select-mode low byte read stalls until the end
    if (read_active & (conv_state == CV_IDLE) & ~start) begin
      if (!fmt_serial) begin
        next_data    = result;
        next_data_oe = '1;
      end else begin
        // byte chosen by upper byte select
        next_data[BYTE_W-1:0]    = sync2[IX_UBS]
                                 ? {{(BYTE_W-NIBBLE_W){1'b0}}, result[RESULT_W-1:BYTE_W]}
                                 : result[BYTE_W-1:0];
        next_data_oe[BYTE_W-1:0] = '1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_data    <= RESULT_RST;
      o_data_oe <= RESULT_RST;
    end else begin
      o_data    <= next_data;
      o_data_oe <= next_data_oe;
    end
  end

  adcif_ser_e         ser_state;
  adcif_ser_e         next_ser_state;
  logic [FRAME_W-1:0] shreg;
  logic [FRAME_W-1:0] next_shreg;
  logic [4:0]         bit_cnt;
  logic [4:0]         next_bit_cnt;
  logic               next_sclk_oe;
  logic               next_serial_data_out_oe;
  logic               next_strobe_oe;
  logic               pop_ready;

  assign pop_if.ready = pop_ready;

  // serial framer; runs the same whichever start mode is chosen
  // one framer for both modes
  always_comb begin
    next_ser_state = ser_state;
    next_shreg     = shreg;
    next_bit_cnt   = bit_cnt;
    next_serial_data_out_oe  = o_serial_data_out_oe;
    next_strobe_oe = o_serial_frame_strobe_n_oe;
    pop_ready      = 1'b0;
    unique case (ser_state)
      SR_IDLE: begin
        if (pop_if.valid) begin
          pop_ready      = 1'b1;
          // four zeros then result, MSB first
          next_shreg     = {{LEAD_ZEROS{1'b0}}, pop_if.data};
          next_ser_state = SR_ARM;
        end
      end
      SR_ARM: begin
        // strobe falls at the first converter clock rise
        if (clk_rise) begin
          next_strobe_oe = 1'b1;
          next_serial_data_out_oe  = ~shreg[FRAME_W-1];
          next_bit_cnt   = 5'h00;
          next_ser_state = SR_SHIFT;
        end
      end
      SR_SHIFT: begin
        // next bit on each rise, sampled on the fall
        if (clk_rise) begin
          if (bit_cnt == 5'(FRAME_W - 1)) begin
            next_strobe_oe = 1'b0;
            next_serial_data_out_oe  = 1'b0;
            next_ser_state = SR_IDLE;
          end else begin
            next_shreg    = {shreg[FRAME_W-2:0], 1'b0};
            next_serial_data_out_oe = ~shreg[FRAME_W-2];
            next_bit_cnt  = bit_cnt + 5'h01;
          end
        end
      end
      default: begin
        next_ser_state = SR_IDLE;
      end
    endcase
    // serial clock follows the converter clock
    // continuous level runs free, gated level only in frame
    // parallel format never toggles the serial clock
    next_sclk_oe = ~sync2[IX_CLK]
                 & ((fmt == FMT_SERIAL_CONT) | (next_ser_state == SR_SHIFT));
  end

  // open-drain pins only ever pull low via their enables
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ser_state                  <= SR_IDLE;
      shreg                      <= '0;
      bit_cnt                    <= 5'h00;
      o_serial_clock_oe          <= 1'b0;
      o_serial_data_out_oe       <= 1'b0;
      o_serial_frame_strobe_n_oe <= 1'b0;
    end else begin
      ser_state                  <= next_ser_state;
      shreg                      <= next_shreg;
      bit_cnt                    <= next_bit_cnt;
      o_serial_clock_oe          <= next_sclk_oe;
      o_serial_data_out_oe       <= next_serial_data_out_oe;
      o_serial_frame_strobe_n_oe <= next_strobe_oe;
    end
  end
endmodule

// ===== rtl/adcif_pkg.sv
/*
  Shared constants of the converter control and result output block.
  Assumes nothing of its surroundings; imported by every design file but the stream interface.
*/
package adcif_pkg;
  // result and serial frame layout
  localparam int RESULT_W   = 12;
  localparam int FRAME_W    = 16;
  localparam int LEAD_ZEROS = FRAME_W - RESULT_W;
  localparam int BYTE_W     = 8;
  localparam int NIBBLE_W   = RESULT_W - BYTE_W;
  localparam int FIFO_DEPTH = 16;
  // converter clock rising edges that one conversion lasts (strobe lead-in plus frame)
  localparam int CONV_TICKS = 19;
  // frame strobe must fall within this many converter clocks of the start
  localparam int STROBE_MAX_CLOCKS = 3;
  // format/clock select level, as two digital flags
  localparam logic [1:0] FMT_SERIAL_GATED = 2'h0;
  localparam logic [1:0] FMT_SERIAL_CONT  = 2'h1;
  localparam logic [1:0] FMT_PARALLEL     = 2'h2;
  // positions in the synchronised input vector
  localparam int SYNC_W      = 8;
  localparam int IX_CLK      = 0;
  localparam int IX_CONVERSION_STROBE_N_N = 1;
  localparam int IX_CS_N     = 2;
  localparam int IX_RD_N     = 3;
  localparam int IX_UBS      = 4;
  localparam int IX_FMT0     = 5;
  localparam int IX_FMT1     = 6;
  localparam int IX_SELMODE  = 7;
  // reset values
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
  localparam logic [SYNC_W-1:0]   SYNC_RST   = 8'h0E;
endpackage

// ===== rtl/adcif_stream_if.sv
/*
  Valid/ready word stream between the conversion logic and the frame buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface adcif_stream_if #(parameter int WIDTH = 12);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ===== rtl/adcif_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides, depth and width as parameters.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module adcif_fifo
  import adcif_pkg::*;
#(
  parameter int WIDTH = RESULT_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic     i_clock,   // block clock
  input  wire logic     i_resetn,  // async reset, active low
  adcif_stream_if.sink   push,     // filling side
  adcif_stream_if.source pop       // draining side
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             full;
  logic             empty;
  logic             do_push;
  logic             do_pop;

  // extra pointer bit tells full from empty without a counter
  assign full       = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty      = (wr_ptr == rd_ptr);
  assign push.ready = ~full;
  assign pop.valid  = ~empty;
  assign pop.data   = mem[rd_ptr[AW-1:0]];
  assign do_push    = push.valid & ~full;
  assign do_pop     = pop.ready & ~empty;

  // pointer advance
  always_comb begin
    next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage carries no reset; only written words are ever read
  always_ff @(posedge i_clock) begin
    if (do_push) begin
      mem[wr_ptr[AW-1:0]] <= push.data;
    end
  end
endmodule

// ===== dv/adcif_chk.sv
/*
  Port checks of the converter control and result output block.
  Assumes the bench's converter clock lasts eight block clocks.
*/
`timescale 1ns/100ps
module adcif_chk
  import adcif_pkg::*;
#(
  parameter int CONVERT_TICKS = CONV_TICKS  // converter clocks per conversion
) (
  input wire logic                i_clock,                    // block clock
  input wire logic                i_resetn,                   // async reset
  input wire logic                i_cs_n,                     // chip select
  input wire logic                i_rd_n,                     // read strobe
  input wire logic [1:0]          i_format_select,            // format level
  input wire logic                i_select_started,           // mode
  input wire logic [RESULT_W-1:0] o_data_oe,                  // pin enables
  input wire logic                o_status_n,                 // interrupt or busy
  input wire logic                o_hold,                     // track/hold
  input wire logic                o_serial_clock_oe,          // clock pull-down
  input wire logic                o_serial_data_out_oe,       // data pull-down
  input wire logic                o_serial_frame_strobe_n_oe  // strobe pull-down
);
  localparam int DIV     = 8;
  localparam int HOLD_LO = (CONVERT_TICKS - 1) * DIV - 2;
  localparam int HOLD_HI = CONVERT_TICKS * DIV + 2;
  logic [8:0] hold_cnt;
  logic [8:0] next_hold_cnt;
  logic [8:0] strb_cnt;
  logic [8:0] next_strb_cnt;
  logic [3:0] idle_cnt;
  logic [3:0] next_idle_cnt;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // span counters; the idle one saturates so long idle stretches stay legal
  always_comb begin
    next_hold_cnt = o_hold ? hold_cnt + 9'h001 : 9'h000;
    next_strb_cnt = o_serial_frame_strobe_n_oe ? strb_cnt + 9'h001 : 9'h000;
    next_idle_cnt = (i_cs_n || i_rd_n) ? idle_cnt + {3'h0, idle_cnt != 4'hF} : 4'h0;
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_cnt <= 9'h000;
      strb_cnt <= 9'h000;
      idle_cnt <= 4'h0;
    end else begin
      hold_cnt <= next_hold_cnt;
      strb_cnt <= next_strb_cnt;
      idle_cnt <= next_idle_cnt;
    end
  end
  a_read_pins_idle: assert property (idle_cnt >= 4'h6 |-> o_data_oe == 12'h000)
    else $error("data pins driven without a read");
  a_no_read_conv: assert property (o_hold && $past(o_hold, 2) |-> o_data_oe == 12'h000)
    else $error("data pins driven during conversion");
  a_top_pins_off: assert property (i_format_select != FMT_PARALLEL
    && $past(i_format_select, 8) == i_format_select |-> o_data_oe[11:8] == 4'h0)
    else $error("top pins driven in byte format");
  a_hold_span: assert property ($fell(o_hold)
    |-> int'(hold_cnt) >= HOLD_LO && int'(hold_cnt) <= HOLD_HI)
    else $error("hold length off");
  a_status_end: assert property ($fell(o_hold)
    && $past(i_select_started, 8) == i_select_started |-> o_status_n == i_select_started)
    else $error("status wrong at conversion end");
  a_busy_low: assert property (o_hold && i_select_started
    && $past(i_select_started, 8) |-> !o_status_n)
    else $error("busy not low in conversion");
  a_int_clear: assert property ($rose(|o_data_oe) && !i_select_started
    && !$past(i_select_started, 8) |-> o_status_n)
    else $error("interrupt not cleared by read");
  a_strobe_soon: assert property ($rose(o_hold) && i_format_select != FMT_PARALLEL
    && $past(i_format_select, 8) == i_format_select |-> ##[0:28] o_serial_frame_strobe_n_oe)
    else $error("frame strobe late");
  a_frame_span: assert property ($fell(o_serial_frame_strobe_n_oe)
    |-> strb_cnt >= 9'h07E && strb_cnt <= 9'h082)
    else $error("frame length off");
  a_data_framed: assert property (o_serial_data_out_oe |-> o_serial_frame_strobe_n_oe)
    else $error("serial data outside frame");
  a_parallel_quiet: assert property (i_format_select == FMT_PARALLEL
    && $past(i_format_select, 8) == FMT_PARALLEL
    |-> !o_serial_frame_strobe_n_oe && !o_serial_clock_oe)
    else $error("serial activity in parallel format");
  a_gated_clock: assert property (i_format_select == FMT_SERIAL_GATED
    && $past(i_format_select, 8) == FMT_SERIAL_GATED
    |-> !o_serial_clock_oe || o_serial_frame_strobe_n_oe)
    else $error("serial clock runs outside frame in gated format");
endmodule

// ===== dv/adcif_host_model.sv
/*
  Serial receiver standing in for the host on the open-drain serial lines.
  Assumes released lines are pulled high; no clock of its own.
*/
`timescale 1ns/100ps
module adcif_host_model
  import adcif_pkg::*;
(
  input  wire logic          i_sclk_oe,  // pulls clock low
  input  wire logic          i_sdat_oe,  // pulls data low
  input  wire logic          i_strb_oe,  // pulls strobe low
  output logic [FRAME_W-1:0] o_word,     // last whole word
  output logic [7:0]         o_count,    // words received
  output logic [4:0]         o_bits      // bits in last frame
);
  logic [FRAME_W-1:0] shift = 16'h0000;
  logic [4:0]         bits  = 5'h00;
  // pull-ups turn every released line high
  wire logic sclk = ~i_sclk_oe;
  wire logic sdat = ~i_sdat_oe;
  wire logic strb = ~i_strb_oe;
  initial begin
    o_word = 16'h0000;
    o_count = 8'h00;
    o_bits = 5'h00;
  end
  // a bit is taken on each falling clock while framed
  always @(negedge sclk) begin
    if (!strb) begin
      shift = {shift[FRAME_W-2:0], sdat};
      bits = bits + 5'h01;
    end
  end
  // frame start clears the count, frame end publishes the word
  always @(negedge strb) begin
    bits = 5'h00;
  end
  always @(posedge strb) begin
    o_word = shift;
    o_bits = bits;
    o_count = o_count + 8'h01;
  end
endmodule

// ===== dv/adcif_top_tb.sv
/*
  Self-checking bench of the converter control block with a serial host model.
  Assumes a 100 MHz clock and a free converter clock of 80 ns.
*/
`timescale 1ns/100ps
bind adcif_top adcif_chk #(.CONVERT_TICKS(CONVERT_TICKS)) i_adcif_chk (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
  .i_format_select(i_format_select), .i_select_started(i_select_started),
  .o_data_oe(o_data_oe), .o_status_n(o_status_n), .o_hold(o_hold),
  .o_serial_clock_oe(o_serial_clock_oe), .o_serial_data_out_oe(o_serial_data_out_oe),
  .o_serial_frame_strobe_n_oe(o_serial_frame_strobe_n_oe));
module adcif_top_tb;
  import adcif_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, conv_clk = 1'b0, strobe_n = 1'b1;
  logic cs_n = 1'b1, rd_n = 1'b1, ubs = 1'b0, sel = 1'b0;
  logic [1:0] fmt = FMT_PARALLEL;
  logic [RESULT_W-1:0] code = 12'hA5C, data, data_oe;
  logic status_n, hold, sclk_oe, sdat_oe, strb_oe, sclk_seen;
  logic [FRAME_W-1:0] rx_word, got, oe;
  logic [7:0] rx_count, rx_seen;
  logic [4:0] rx_bits;
  int failures = 0, cmp_count = 0;
  adcif_top #(.CONVERT_TICKS(CONV_TICKS), .POWERUP_CONV(1'b1)) i_adcif_top (
    .i_clock(clock), .i_resetn(resetn), .i_conv_clock(conv_clk),
    .i_conversion_strobe_n(strobe_n), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_upper_byte_select(ubs), .i_format_select(fmt), .i_select_started(sel),
    .i_sample_code(code), .o_data(data), .o_data_oe(data_oe), .o_status_n(status_n),
    .o_hold(hold), .o_serial_clock_oe(sclk_oe), .o_serial_data_out_oe(sdat_oe),
    .o_serial_frame_strobe_n_oe(strb_oe));
  adcif_host_model i_adcif_host_model (
    .i_sclk_oe(sclk_oe), .i_sdat_oe(sdat_oe), .i_strb_oe(strb_oe),
    .o_word(rx_word), .o_count(rx_count), .o_bits(rx_bits));
  // clocks; the converter clock is offset so no edge meets the block clock
  always #5 clock = ~clock;
  initial begin
    #3;
    forever #40 conv_clk = ~conv_clk;
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_word({15'h0000, g}, {15'h0000, e});
  endtask
  // bounded wait for the hold output to reach a level
  task automatic wait_hold(input logic lvl);
    int n;
    n = 0;
    while (hold !== lvl && n < 400) begin
      @(negedge clock);
      n++;
    end
    if (hold !== lvl) begin
      failures++;
      wrap_up();
    end
  endtask
  // strobe-mode start: low pulse, conversion runs to its end
  task automatic convert;
    @(negedge clock);
    strobe_n = 1'b0;
    repeat (4) @(negedge clock);
    strobe_n = 1'b1;
    wait_hold(1'b1);
    wait_hold(1'b0);
  endtask
  // read cycle; strobe is left as the caller set it and select/read are released again
  task automatic read(input logic upper, output logic [15:0] v, output logic [15:0] en);
    int n;
    n = 0;
    @(negedge clock);
    ubs = upper;
    @(negedge clock);
    cs_n = 1'b0;
    rd_n = 1'b0;
    while (data_oe === 12'h000 && n < 400) begin
      @(negedge clock);
      n++;
    end
    if (n == 400) begin
      failures++;
      wrap_up();
    end
    v = {4'h0, data & data_oe};
    en = {4'h0, data_oe};
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (8) @(negedge clock);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    wait_hold(1'b1);
    wait_hold(1'b0);
    chk_bit(status_n, 1'b0);
    read(1'b0, got, oe);
    chk_word(got, 16'h0A5C);
    chk_bit(status_n, 1'b1);
    code = 12'h3C7;
    convert();
    chk_bit(status_n, 1'b0);
    read(1'b0, got, oe);
    chk_word(got, 16'h03C7);
    chk_word(oe, 16'h0FFF);
    chk_bit(status_n, 1'b1);
    cs_n = 1'b0;
    strobe_n = 1'b0;
    repeat (4) @(negedge clock);
    strobe_n = 1'b1;
    repeat (40) @(negedge clock);
    chk_bit(hold, 1'b0);
    cs_n = 1'b1;
    // both serial clock options, byte reads of each result
    for (int k = 0; k < 2; k++) begin
      fmt = k ? FMT_SERIAL_CONT : FMT_SERIAL_GATED;
      code = k ? 12'h80F : 12'hB6D;
      rx_seen = rx_count;
      repeat (8) @(negedge clock);
      convert();
      chk_word({8'h00, rx_count - rx_seen}, 16'h0001);
      chk_word(rx_word, {4'h0, code});
      chk_word({11'h000, rx_bits}, 16'h0010);
      read(1'b0, got, oe);
      chk_word(got, {8'h00, code[7:0]});
      chk_word(oe, 16'h00FF);
      read(1'b1, got, oe);
      chk_word(got, {12'h000, code[11:8]});
      // between frames the clock pulls low only in the continuous format
      sclk_seen = 1'b0;
      repeat (16) begin
        @(negedge clock);
        sclk_seen = sclk_seen | sclk_oe;
      end
      chk_bit(sclk_seen, k[0]);
    end
    sel = 1'b1;
    strobe_n = 1'b0;
    fmt = FMT_SERIAL_GATED;
    code = 12'h5E1;
    rx_seen = rx_count;
    repeat (8) @(negedge clock);
    read(1'b0, got, oe);
    chk_word(got, 16'h00E1);
    chk_bit(status_n, 1'b1);
    chk_word(rx_word, 16'h05E1);
    chk_word({8'h00, rx_count - rx_seen}, 16'h0001);
    read(1'b1, got, oe);
    chk_word(got, 16'h0005);
    fmt = FMT_PARALLEL;
    code = 12'hFFF;
    repeat (8) @(negedge clock);
    read(1'b0, got, oe);
    chk_word(got, 16'h0FFF);
    chk_word({8'h00, rx_count - rx_seen}, 16'h0001);
    wrap_up();
  end
endmodule
